// [dltc_regs.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module dltc_regs
    import dltc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    // Controls to the line path
    output logic                   double_scale_sel,
    output logic [3:0]             line_impedance_sel,
    output logic                   ext_scale_sel,
    output logic [1:0]             hook_engage_time,
    output logic [31:0]            hook_engage_cycles,
    output logic                   release_speed_hi,
    output logic                   release_speed_lo,
    output logic [1:0]             spark_quench_sel,
    output logic [1:0]             release_class,
    output logic                   rx_corner_sel,
    output logic                   bit_zero_ctrl
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < 7) begin : g_bad_addr_w
        $error("dltc_regs: ADDR_W must be at least 7");
    end

    logic [7:0]  ac_impedance_ctrl;
    logic [7:0]  line_control_five;
    logic [7:0]  release_ctrl;
    logic [7:0]  next_ac_impedance_ctrl;
    logic [7:0]  next_line_control_five;
    logic [7:0]  next_release_ctrl;
    logic [7:0]  next_reg_rdata;
    logic [31:0] next_engage_cycles;
    dltc_release_t next_release_class;
    logic        hit_ac;
    logic        hit_five;
    logic        hit_rel;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign hit_ac   = (reg_addr == ADDR_W'(ADDR_AC_IMPEDANCE_CTRL));
    assign hit_five = (reg_addr == ADDR_W'(ADDR_LINE_CONTROL_FIVE));
    assign hit_rel  = (reg_addr == ADDR_W'(ADDR_RELEASE_CTRL));

    // Next register values and read data
    always_comb begin
        next_ac_impedance_ctrl = ac_impedance_ctrl;
        next_line_control_five = line_control_five;
        next_release_ctrl      = release_ctrl;
        next_reg_rdata         = 8'h00;
        if (reg_wr) begin
            if (hit_ac) begin
                next_ac_impedance_ctrl = reg_wdata & MASK_AC_IMPEDANCE_CTRL;
            end
            if (hit_five) begin
                next_line_control_five = reg_wdata & MASK_LINE_CONTROL_FIVE;
            end
            if (hit_rel) begin
                next_release_ctrl = reg_wdata & MASK_RELEASE_CTRL;
            end
        end
        if (reg_rd) begin
            if (hit_ac) begin
                next_reg_rdata = ac_impedance_ctrl;
            end else if (hit_five) begin
                next_reg_rdata = line_control_five;
            end else if (hit_rel) begin
                next_reg_rdata = release_ctrl;
            end else begin
                next_reg_rdata = 8'h00;  // Unmapped reads zero
            end
        end
    end

    always_comb begin
        case (next_line_control_five[POS_ENGAGE_HI:POS_ENGAGE_LO])
            2'b00:   next_engage_cycles = 32'(ENGAGE_CYC_00);
            2'b01:   next_engage_cycles = 32'(ENGAGE_CYC_01);
            2'b10:   next_engage_cycles = 32'(ENGAGE_CYC_10);
            2'b11:   next_engage_cycles = 32'(ENGAGE_CYC_11);
            default: next_engage_cycles = 32'(ENGAGE_CYC_01);
        endcase
    end

    always_comb begin
        case ({next_release_ctrl[POS_RELEASE_LO],
               next_line_control_five[POS_RELEASE_HI],
               next_release_ctrl[POS_QUENCH_HI:0]})
            4'b0000: next_release_class = DLTC_REL_FAST;
            4'b0100: next_release_class = DLTC_REL_MEDIUM;
            4'b1011: next_release_class = DLTC_REL_SLOW;
            4'b1111: next_release_class = DLTC_REL_SLOW;
            default: next_release_class = DLTC_REL_OTHER;
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ac_impedance_ctrl  <= RST_AC_IMPEDANCE_CTRL;
            line_control_five  <= RST_LINE_CONTROL_FIVE;
            release_ctrl       <= RST_RELEASE_CTRL;
            reg_rdata          <= 8'h00;
            hook_engage_cycles <= 32'(ENGAGE_CYC_01);
            release_class      <= DLTC_REL_FAST;
        end else if (clk_en) begin
            ac_impedance_ctrl  <= next_ac_impedance_ctrl;
            line_control_five  <= next_line_control_five;
            release_ctrl       <= next_release_ctrl;
            reg_rdata          <= next_reg_rdata;
            hook_engage_cycles <= next_engage_cycles;
            release_class      <= next_release_class;
        end
    end

    // ------------------------------------------------------------
    // Field outputs, straight from the registers
    // ------------------------------------------------------------
    // Doubled scale select
    assign double_scale_sel   = ac_impedance_ctrl[POS_DOUBLE_SCALE];
    assign line_impedance_sel = ac_impedance_ctrl[POS_IMPEDANCE_HI:0];
    assign ext_scale_sel      = line_control_five[POS_EXT_SCALE];
    assign hook_engage_time   = line_control_five[POS_ENGAGE_HI:POS_ENGAGE_LO];
    assign release_speed_hi   = line_control_five[POS_RELEASE_HI];
    assign release_speed_lo   = release_ctrl[POS_RELEASE_LO];
    assign spark_quench_sel   = release_ctrl[POS_QUENCH_HI:0];
    assign rx_corner_sel      = line_control_five[POS_RX_CORNER];
    assign bit_zero_ctrl      = line_control_five[POS_BIT_ZERO];

endmodule // dltc_regs

// [dltc_pkg.sv]
// How it works
// - Impedance bit 5 stored, no effect
// - Bit 4 selects doubled full scale
// - Bits 3:0 select termination network
// - Bit 7 selects extended full scale
// - Bits 6:5 set off-hook counter length
// - Release speed from three joint selects
// - Bit 1 selects receive corner frequency
package dltc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_AC_IMPEDANCE_CTRL = 8'h1e;
    localparam logic [7:0] ADDR_LINE_CONTROL_FIVE = 8'h1f;
    localparam logic [7:0] ADDR_RELEASE_CTRL      = 8'h40;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_AC_IMPEDANCE_CTRL = 8'h00;
    localparam logic [7:0] RST_LINE_CONTROL_FIVE = 8'h20;
    localparam logic [7:0] RST_RELEASE_CTRL      = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_SPARE_BIT5      = 5;
    localparam int POS_DOUBLE_SCALE    = 4;
    localparam int POS_IMPEDANCE_HI    = 3;
    localparam int POS_EXT_SCALE       = 7;
    localparam int POS_ENGAGE_HI       = 6;
    localparam int POS_ENGAGE_LO       = 5;
    localparam int POS_RELEASE_HI      = 3;
    localparam int POS_RX_CORNER       = 1;
    localparam int POS_BIT_ZERO        = 0;
    localparam int POS_RELEASE_LO      = 2;
    localparam int POS_QUENCH_HI       = 1;

    // Bits kept in each register (control five reserved 4 and 2 read zero)
    localparam logic [7:0] MASK_LINE_CONTROL_FIVE = 8'heb;
    localparam logic [7:0] MASK_AC_IMPEDANCE_CTRL = 8'h3f;
    localparam logic [7:0] MASK_RELEASE_CTRL      = 8'h07;

    // ------------------------------------------------------------
    // Off-hook counter lengths in ms and in cycles at 250 MHz
    // ------------------------------------------------------------
    localparam longint CLK_HZ       = 64'd250_000_000;
    localparam longint ENGAGE_MS_00 = 64'd512;
    localparam longint ENGAGE_MS_01 = 64'd128;
    localparam longint ENGAGE_MS_10 = 64'd64;
    localparam longint ENGAGE_MS_11 = 64'd8;
    localparam longint ENGAGE_CYC_00 = ENGAGE_MS_00 * CLK_HZ / 64'd1000;
    localparam longint ENGAGE_CYC_01 = ENGAGE_MS_01 * CLK_HZ / 64'd1000;
    localparam longint ENGAGE_CYC_10 = ENGAGE_MS_10 * CLK_HZ / 64'd1000;
    localparam longint ENGAGE_CYC_11 = ENGAGE_MS_11 * CLK_HZ / 64'd1000;

    // ------------------------------------------------------------
    // Release speed classes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DLTC_REL_FAST   = 2'b00,  // Under 0.5 ms
        DLTC_REL_MEDIUM = 2'b01,  // About 3 ms
        DLTC_REL_SLOW   = 2'b11,  // About 26 ms
        DLTC_REL_OTHER  = 2'b10   // Undefined combination
    } dltc_release_t;

endpackage

// [dltc_regs_monitor.sv]
`timescale 1ns/10ps
module dltc_regs_monitor
    import dltc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset and bus
    input wire logic              clk, arst_n, clk_en, reg_wr, reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata, reg_rdata,
    // Field outputs
    input wire logic              double_scale_sel, ext_scale_sel, rx_corner_sel,
    input wire logic              bit_zero_ctrl, release_speed_lo,
    input wire logic [3:0]        line_impedance_sel,
    input wire logic [1:0]        spark_quench_sel, release_class,
    input wire logic [31:0]       hook_engage_cycles
);
    localparam logic [31:0] CYC [4] = '{32'd128000000, 32'd32000000, 32'd16000000, 32'd2000000};
    logic wr_ac;
    logic wr_five;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Accepted writes to the AC impedance and control five registers
    assign wr_ac   = reg_wr && clk_en && reg_addr == 8'h1e;
    assign wr_five = reg_wr && clk_en && reg_addr == 8'h1f;
    ac_readback_a: assert property (wr_ac ##1 (reg_rd && clk_en && reg_addr == 8'h1e)
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f)) else $error("ac readback wrong");
    double_scale_a: assert property (wr_ac |=> double_scale_sel == $past(reg_wdata[4]))
        else $error("double scale wrong");
    impedance_sel_a: assert property (wr_ac |=> line_impedance_sel == $past(reg_wdata[3:0]))
        else $error("impedance select wrong");
    ext_scale_a: assert property (wr_five |=> ext_scale_sel == $past(reg_wdata[7]))
        else $error("extended scale wrong");
    engage_len_a: assert property (wr_five |=> hook_engage_cycles == CYC[$past(reg_wdata[6:5])])
        else $error("engage length wrong");
    resv_zero_a: assert property (reg_rd && clk_en && reg_addr == 8'h1f
        |=> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0) else $error("reserved bits not zero");
    slow_release_a: assert property ((release_speed_lo && spark_quench_sel == 2'b11) [*2]
        |-> release_class == 2'b11) else $error("release class wrong");
    rx_corner_a: assert property (wr_five |=> rx_corner_sel == $past(reg_wdata[1]))
        else $error("corner select wrong");
    bit_zero_a: assert property (wr_five |=> bit_zero_ctrl == $past(reg_wdata[0]))
        else $error("bit zero wrong");
endmodule // dltc_regs_monitor

bind dltc_regs dltc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk, .arst_n, .clk_en, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .double_scale_sel, .ext_scale_sel, .rx_corner_sel,
    .bit_zero_ctrl, .release_speed_lo, .line_impedance_sel, .spark_quench_sel, .release_class,
    .hook_engage_cycles);

// [dltc_host.sv]
`timescale 1ns/10ps
module dltc_host #(
    parameter bit BASIC = 1'b0
) (
    // Bus
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      reg_addr, reg_wdata,
    output logic            reg_wr, reg_rd
);
    // Idle bus at time zero
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // Write one byte, strobe high for one cycle only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h1f) v = v & (BASIC ? 8'h6b : 8'heb);
        else if (a == 8'h1e && BASIC) v = v & 8'hf2;
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read one byte, data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule // dltc_host

// [daa_line_termination_ctrl_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module daa_line_termination_ctrl_tb;
    import dltc_pkg::*;
    localparam logic [31:0] CYC [4] = '{32'd128000000, 32'd32000000, 32'd16000000, 32'd2000000};
    logic        clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, v;
    logic        reg_wr, reg_rd, double_scale_sel, ext_scale_sel, rx_corner_sel, bit_zero_ctrl;
    logic        release_speed_hi, release_speed_lo;
    logic [3:0]  line_impedance_sel;
    logic [1:0]  hook_engage_time, spark_quench_sel, release_class;
    logic [31:0] hook_engage_cycles;
    int          error_cnt = 0, n_compared = 0;
    always #2 clk = ~clk;
    dltc_regs #(.ADDR_W(8)) u_dut (.clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .double_scale_sel, .line_impedance_sel, .ext_scale_sel,
        .hook_engage_time, .hook_engage_cycles, .release_speed_hi, .release_speed_lo,
        .spark_quench_sel, .release_class, .rx_corner_sel, .bit_zero_ctrl);
    dltc_host u_host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    task automatic conclude;
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Defaults after reset
    task automatic t_reset;
        u_host.rd(8'h1e, d); `CHK("ac reset", RST_AC_IMPEDANCE_CTRL, d)
        u_host.rd(8'h1f, d); `CHK("five reset", RST_LINE_CONTROL_FIVE, d)
        `CHK("engage default", CYC[1], hook_engage_cycles)
    endtask
    // Every impedance code, spare and scale bits toggled
    task automatic t_ac;
        for (int i = 0; i < 16; i++) begin
            v = {2'b11, ~i[0], i[0], i[3:0]};
            u_host.wr(8'h1e, v);
            u_host.rd(8'h1e, d); `CHK("ac readback", v & 8'h3f, d)
            `CHK("double scale", v[4], double_scale_sel)
            `CHK("impedance", v[3:0], line_impedance_sel)
        end
    endtask
    // Every engage length with other fields varied
    task automatic t_five;
        // Write while frozen must not land
        @(posedge clk);
        clk_en <= 1'b0;
        u_host.wr(8'h1e, 8'h15);
        @(posedge clk);
        clk_en <= 1'b1;
        u_host.rd(8'h1e, d); `CHK("frozen write", 8'h1f, d)
        for (int k = 0; k < 4; k++) begin
            v = {k[0], k[1:0], 1'b1, k[1], 1'b1, ~k[0], k[0]};
            u_host.wr(8'h1f, v);
            u_host.rd(8'h1f, d); `CHK("five readback", v & 8'heb, d)
            `CHK("engage cycles", CYC[k], hook_engage_cycles)
            `CHK("engage time", k[1:0], hook_engage_time)
            `CHK("ext scale", v[7], ext_scale_sel)
            `CHK("rx corner", v[1], rx_corner_sel)
            `CHK("bit zero", v[0], bit_zero_ctrl)
        end
    endtask
    // Release speed classes, writes one idle cycle apart
    task automatic t_release;
        logic [7:0] f [3] = '{8'h08, 8'h08, 8'h00};
        logic [7:0] r [3] = '{8'h00, 8'h07, 8'h00};
        logic [1:0] e [3] = '{2'b01, 2'b11, 2'b00};
        for (int j = 0; j < 3; j++) begin
            u_host.wr(8'h1f, f[j]);
            u_host.wr(8'h40, r[j]);
            u_host.rd(8'h40, d);
            `CHK("release class", e[j], release_class)
            `CHK("speed hi", f[j][3], release_speed_hi)
            `CHK("speed lo", r[j][2], release_speed_lo)
            `CHK("quench", r[j][1:0], spark_quench_sel)
            `CHK("release readback", r[j], d)
        end
        u_host.wr(8'h55, 8'hff);
        u_host.rd(8'h55, d); `CHK("unmapped read", 8'h00, d)
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_ac;
        t_five;
        t_release;
        conclude;
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        conclude;
    end
endmodule // daa_line_termination_ctrl_tb
